// >>> bench/chipset_model.sv
// Chipset model: clock stop control, wake on break, shutdown answer
`timescale 1ns/100ps
module chipset_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Bench controls
  input  wire logic stop_want_i,
  input  wire logic wake_en_i,
  // Device pins and bus
  input  wire logic fp_error_break_out_n_i,
  input  wire logic shutdown_req_i,
  output logic      clock_stop_request_n_o,
  output logic      shutdown_ack_o,
  output logic      nmi_o
);
  logic woke_reg;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      woke_reg               <= 1'b0;
      clock_stop_request_n_o <= 1'b1;
      shutdown_ack_o         <= 1'b0;
      nmi_o                  <= 1'b0;
    end else begin
      if (!stop_want_i)
        woke_reg <= 1'b0;
      else if (wake_en_i && !clock_stop_request_n_o && !fp_error_break_out_n_i)
        woke_reg <= 1'b1;
      clock_stop_request_n_o <= !(stop_want_i && !woke_reg);
      shutdown_ack_o         <= shutdown_req_i;
      nmi_o                  <= nmi_o | shutdown_req_i;
    end
  end
endmodule : chipset_model

// >>> bench/cpu_error_break_signalling_test.sv
// Self-checking bench for the error and break signalling block
`timescale 1ns/100ps
module cpu_error_break_signalling_test;
  localparam logic [4:0] E_FP    = 5'h10;
  localparam logic [4:0] E_FPCLR = 5'h08;
  localparam logic [4:0] E_BRK   = 5'h04;
  localparam logic [4:0] E_BKCLR = 5'h02;
  localparam logic [4:0] E_FAULT = 5'h01;
  logic core_clk_i, nrst_i, stop_want, wake_en, fp_mask_i;
  logic stop_n, ack, nmi, sd_req, pin_n, fault_n;
  err_break_pkg::core_event_s evt;
  int   fails, n_compared;

  chipset_model partner (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .stop_want_i(stop_want), .wake_en_i(wake_en),
    .fp_error_break_out_n_i(pin_n), .shutdown_req_i(sd_req),
    .clock_stop_request_n_o(stop_n), .shutdown_ack_o(ack), .nmi_o(nmi));
  cpu_error_break_signalling dut (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .clock_stop_request_n_i(stop_n), .core_evt_i(evt),
    .fp_mask_i(fp_mask_i), .shutdown_ack_i(ack), .shutdown_req_o(sd_req),
    .fp_error_break_out_n_o(pin_n), .internal_fault_out_n_o(fault_n));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick

  // Event held for one edge, then one quiet edge
  task automatic pulse(input logic [4:0] e);
    evt = err_break_pkg::core_event_s'(e);
    tick(1);
    evt = err_break_pkg::core_event_s'(5'h00);
    tick(1);
  endtask : pulse

  // Bounded wait on the shutdown request (pick_req) or the stop pin
  task automatic wait_lvl(input bit pick_req, input logic val);
    logic cur;
    cur = pick_req ? sd_req : stop_n;
    for (int i = 0; i < 20 && cur !== val; i++) begin
      tick(1);
      cur = pick_req ? sd_req : stop_n;
    end
    if (cur !== val) begin
      fails++;
      end_sim();
    end
  endtask : wait_lvl

  ////////////////////////////////////////////////////////////////////////
  task automatic t_fp;
    fp_mask_i = 1'b1;
    pulse(E_FP);
    check(pin_n, 1'b1);
    fp_mask_i = 1'b0;
    tick(2);
    check(pin_n, 1'b0);
    pulse(E_FPCLR);
    check(pin_n, 1'b1);
    pulse(E_FP | E_FPCLR);
    check(pin_n, 1'b0);
  endtask : t_fp

  task automatic t_break;
    stop_want = 1'b1;
    tick(5);
    check(pin_n, 1'b1);
    pulse(E_BRK);
    check(pin_n, 1'b0);
    pulse(E_BKCLR);
    check(pin_n, 1'b1);
    wake_en = 1'b1;
    pulse(E_BRK);
    wait_lvl(1'b0, 1'b1);
    tick(4);
    check(pin_n, 1'b0);
    pulse(E_FPCLR);
    check(pin_n, 1'b1);
    stop_want = 1'b0;
    wake_en = 1'b0;
    pulse(E_BKCLR);
  endtask : t_break

  task automatic t_fault;
    pulse(E_FAULT);
    check(fault_n, 1'b0);
    check(sd_req, 1'b1);
    check(nmi, 1'b1);
    wait_lvl(1'b1, 1'b0);
    pulse(E_FAULT);
    tick(20);
    check(fault_n, 1'b0);
    check(sd_req, 1'b0);
    check(pin_n, 1'b1);
    nrst_i = 1'b0;
    tick(1);
    check(fault_n, 1'b1);
    nrst_i = 1'b1;
    tick(2);
    check(sd_req, 1'b0);
    check(pin_n, 1'b1);
    pulse(E_FAULT);
    check(fault_n, 1'b0);
    check(sd_req, 1'b1);
  endtask : t_fault

  initial begin
    nrst_i = 1'b0;
    stop_want = 1'b0;
    wake_en = 1'b0;
    fp_mask_i = 1'b0;
    evt = err_break_pkg::core_event_s'(5'h00);
    fails = 0;
    n_compared = 0;
    tick(8);
    nrst_i = 1'b1;
    tick(2);
    check(pin_n, 1'b1);
    check(fault_n, 1'b1);
    check(sd_req, 1'b0);
    t_fp();
    t_break();
    t_fault();
    end_sim();
  end
endmodule : cpu_error_break_signalling_test

// >>> rtl/cpu_error_break_signalling.sv
// Shared FP-error / pending-break pin and sticky internal-fault pin
//
// How it works
// - One shared pin: FP errors when clock stop idle, breaks when active.
// - Clock stop idle: pin asserts while an unmasked FP error is pending.
// - Clock stop active: pin asserts only for a pending break event.
// - Internal fault asserts the internal-fault pin.
// - Internal-fault pin stays asserted until reset.
// - The first internal fault after reset also requests one shutdown bus transaction.
`timescale 1ns/100ps
module cpu_error_break_signalling (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  // Clock stop request pin, active low, asynchronous
  input  wire logic                       clock_stop_request_n_i,
  // Core events and FP mask
  input  wire err_break_pkg::core_event_s core_evt_i,
  input  wire logic                       fp_mask_i,
  // Bus unit shutdown handshake
  input  wire logic                       shutdown_ack_i,
  output logic                            shutdown_req_o,
  // Pins toward the chipset, active low
  output logic                            fp_error_break_out_n_o,
  output logic                            internal_fault_out_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock stop request synchronisation

  logic stop_n_sync;
  logic stop_q;

  pin_sync #(
    .RESET_LEVEL (err_break_pkg::PIN_DEASSERTED)
  ) u_stop_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (clock_stop_request_n_i),
    .level_o    (stop_n_sync)
  );

  assign stop_q = ~stop_n_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags and shared pin

  logic fp_pending_reg;
  logic fp_pending_next;
  logic brk_pending_reg;
  logic brk_pending_next;
  logic shared_n_reg;
  logic shared_n_next;

  // Set wins over clear on the same cycle
  function automatic logic sticky_next(input logic cur,
                                       input logic set,
                                       input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction : sticky_next

  always_comb begin
    fp_pending_next  = sticky_next(fp_pending_reg, core_evt_i.fp_error,
                                   core_evt_i.fp_clear);
    brk_pending_next = sticky_next(brk_pending_reg, core_evt_i.break_event,
                                   core_evt_i.break_clear);
    if (stop_q) begin
      shared_n_next = brk_pending_next ? err_break_pkg::PIN_ASSERTED
                                       : err_break_pkg::PIN_DEASSERTED;
    end else begin
      shared_n_next = (fp_pending_next && !fp_mask_i)
                      ? err_break_pkg::PIN_ASSERTED
                      : err_break_pkg::PIN_DEASSERTED;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fp_pending_reg  <= err_break_pkg::FLAG_CLEAR;
      brk_pending_reg <= err_break_pkg::FLAG_CLEAR;
      shared_n_reg    <= err_break_pkg::PIN_DEASSERTED;
    end else begin
      fp_pending_reg  <= fp_pending_next;
      brk_pending_reg <= brk_pending_next;
      shared_n_reg    <= shared_n_next;
    end
  end

  assign fp_error_break_out_n_o = shared_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Internal fault and shutdown request

  logic                          fault_n_reg;
  logic                          fault_n_next;
  err_break_pkg::shutdown_state_e sd_state_reg;
  err_break_pkg::shutdown_state_e sd_state_next;
  logic                          sd_req_reg;
  logic                          sd_req_next;

  always_comb begin
    fault_n_next = fault_n_reg;
    if (core_evt_i.internal_fault) begin
      fault_n_next = err_break_pkg::PIN_ASSERTED;
    end
  end

  // Only one shutdown per fault episode; a reset re-arms it
  always_comb begin
    sd_state_next = sd_state_reg;
    case (sd_state_reg)
      err_break_pkg::SD_IDLE: begin
        if (core_evt_i.internal_fault) begin
          sd_state_next = err_break_pkg::SD_REQ;
        end
      end
      err_break_pkg::SD_REQ: begin
        if (shutdown_ack_i) begin
          sd_state_next = err_break_pkg::SD_DONE;
        end
      end
      err_break_pkg::SD_DONE: begin
        sd_state_next = err_break_pkg::SD_DONE;
      end
      default: begin
        sd_state_next = err_break_pkg::SD_IDLE;
      end
    endcase
    sd_req_next = (sd_state_next == err_break_pkg::SD_REQ);
  end

  // Fault pin has no clear path other than reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_n_reg  <= err_break_pkg::PIN_DEASSERTED;
      sd_state_reg <= err_break_pkg::SD_IDLE;
      sd_req_reg   <= err_break_pkg::FLAG_CLEAR;
    end else begin
      fault_n_reg  <= fault_n_next;
      sd_state_reg <= sd_state_next;
      sd_req_reg   <= sd_req_next;
    end
  end

  assign internal_fault_out_n_o = fault_n_reg;
  assign shutdown_req_o         = sd_req_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_fault_in;
    core_evt_i.internal_fault;
  endsequence

  sequence s_fault_pin_low;
    !internal_fault_out_n_o;
  endsequence

  sequence s_req_up;
    shutdown_req_o ##0 !internal_fault_out_n_o;
  endsequence

  a_fp_error_report: assert property (
    (!stop_q && core_evt_i.fp_error && !fp_mask_i) |=>
      !fp_error_break_out_n_o)
    else $error("FP error not reported on shared pin");

  a_fp_masked_quiet: assert property (
    (!stop_q && fp_mask_i) |=> fp_error_break_out_n_o)
    else $error("Masked FP error reached shared pin");

  a_fp_pending_hold: assert property (
    (!stop_q && fp_pending_reg && !fp_mask_i && !core_evt_i.fp_clear) |=>
      !fp_error_break_out_n_o)
    else $error("Pending FP error dropped from shared pin");

  a_break_report: assert property (
    (stop_q && core_evt_i.break_event) |=> !fp_error_break_out_n_o)
    else $error("Pending break not reported during clock stop");

  a_break_only_stop: assert property (
    (stop_q && !brk_pending_reg && !core_evt_i.break_event) |=>
      fp_error_break_out_n_o)
    else $error("Shared pin asserted in clock stop without break");

  a_quiet_no_cause: assert property (
    !fp_error_break_out_n_o |-> (fp_pending_reg || brk_pending_reg))
    else $error("Shared pin asserted with nothing pending");

  a_fault_assert: assert property (
    s_fault_in |=> s_fault_pin_low)
    else $error("Internal fault pin not asserted after fault");

  a_fault_hold: assert property (
    s_fault_pin_low |=> s_fault_pin_low [*8])
    else $error("Internal fault pin released before reset");

  a_shutdown_issue: assert property (
    $fell(internal_fault_out_n_o) |-> s_req_up)
    else $error("Internal fault without shutdown request");

  a_shutdown_wait: assert property (
    (shutdown_req_o && !shutdown_ack_i) |=> shutdown_req_o)
    else $error("Shutdown request withdrawn before acknowledge");

  a_shutdown_once: assert property (
    (shutdown_req_o && shutdown_ack_i) |=> !shutdown_req_o [*4])
    else $error("Shutdown request repeated after acknowledge");

  a_fp_quiet_idle: assert property (
    (!stop_q && !fp_pending_reg && !core_evt_i.fp_error) |=>
      fp_error_break_out_n_o)
    else $error("Shared pin asserted with no FP error pending");

  a_break_pending_hold: assert property (
    (stop_q && brk_pending_reg && !core_evt_i.break_clear) |=>
      !fp_error_break_out_n_o)
    else $error("Pending break dropped during clock stop");

endmodule : cpu_error_break_signalling

// >>> rtl/err_break_pkg.sv
// Shared constants and types for the error and break signalling block
package err_break_pkg;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;

  // Reset and idle levels of active-low pins
  localparam logic PIN_DEASSERTED = 1'b1;
  localparam logic PIN_ASSERTED   = 1'b0;

  // Reset level of internal flags
  localparam logic FLAG_CLEAR = 1'b0;
  localparam logic FLAG_SET   = 1'b1;

  // Shutdown request sequencing
  typedef enum logic [1:0] {
    SD_IDLE = 2'b00,
    SD_REQ  = 2'b01,
    SD_DONE = 2'b10
  } shutdown_state_e;

  // Same-clock events from the execution core
  typedef struct packed {
    logic fp_error;       // Unmasked-or-not FP error detected
    logic fp_clear;       // FP error status cleared by software
    logic break_event;    // Break event arrived
    logic break_clear;    // Break event taken into service
    logic internal_fault; // Internal fault detected
  } core_event_s;

endpackage : err_break_pkg

// >>> rtl/pin_sync.sv
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Pin and synchronised level
  input  wire logic pin_i,
  output logic      level_o
);

  logic [err_break_pkg::SYNC_STAGES-1:0] stage_reg;
  logic [err_break_pkg::SYNC_STAGES-1:0] stage_next;

  // First stage feeds only the next stage
  always_comb begin
    stage_next[0] = pin_i;
  end

  genvar g;
  generate
    for (g = 1; g < err_break_pkg::SYNC_STAGES; g++) begin : g_chain
      always_comb begin
        stage_next[g] = stage_reg[g-1];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_reg <= {err_break_pkg::SYNC_STAGES{RESET_LEVEL}};
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign level_o = stage_reg[err_break_pkg::SYNC_STAGES-1];

endmodule : pin_sync
